/* File: bench/icu_partner.sv */
// far-side model: field contacts and a peer relay light pin
`timescale 1ns/1ps
`default_nettype none
module icu_partner #(
  parameter int unsigned N = 12
) (
  // clock
  input wire logic clk,
  // commanded levels
  input wire logic [N-1:0] next_raw,
  input wire logic next_light,
  // wires seen by the relay
  output logic [N-1:0] raw,
  output logic light
);
  // contacts move one clock after the command, like real wiring lag
  initial begin
    raw = '0;
    light = 1'b0;
  end
  always @(posedge clk) begin
    raw <= next_raw;
    light <= next_light;
  end
endmodule : icu_partner
`default_nettype wire

/* File: bench/input_conditioning_unit_tb.sv */
// self-checking bench for the input conditioning unit
`timescale 1ns/1ps
`default_nettype none
module input_conditioning_unit_tb;
  import icu_pkg::*;
  localparam int N = 12;
  logic clk, rst, wr, rd, route, light, light_n, peer_in_st, peer_out;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv, seed;
  logic [N-1:0] raw, raw_n, present, state, on_e, off_e, alarm, rf;
  logic [N-1:0] pol, on_en, off_en, al_en, norm_m;
  logic [3:0] soft_in;
  logic [5:0] soft_out;
  int fail_count, checks;
  int on_x[N], off_x[N], al_x[N], cnt[N], on_n[N], off_n[N], al_n[N];
  icu_top #(.N_IN(N), .PER_SLOT(6), .STEP_CYC(4)) icu_top_i (
    .CORE_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CONTACT_INPUT(raw),
    .CONTACT_PRESENT(present), .CONTACT_STATE(state),
    .SOFT_INPUT(soft_in), .SOFT_OUTPUT(soft_out), .ON_EVENT(on_e),
    .OFF_EVENT(off_e), .ALARM_POPUP(alarm), .PEER_LIGHT_INPUT(light),
    .PEER_LIGHT_ROUTE(route), .PEER_LIGHT_IN_STATE(peer_in_st),
    .PEER_LIGHT_OUTPUT(peer_out));
  icu_partner #(.N(N)) icu_partner_i (.clk(clk), .next_raw(raw_n),
    .next_light(light_n), .raw(raw), .light(light));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // counting pulses per cycle also catches a pulse that sticks
  always @(posedge clk) begin
    #1;
    for (int i = 0; i < N; i++) begin
      on_n[i] += int'(on_e[i] === 1'b1);
      off_n[i] += int'(off_e[i] === 1'b1);
      al_n[i] += int'(alarm[i] === 1'b1);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (e !== g) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bw
  task automatic br(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : br
  // model: edges of the polarity-corrected, present-masked level
  task automatic mstep(input logic [N-1:0] r);
    logic [N-1:0] nn;
    nn = (r ^ pol) & present;
    for (int i = 0; i < N; i++) begin
      if (nn[i] && !norm_m[i]) begin
        cnt[i] = (cnt[i] + 1) % 65536;
        on_x[i] += int'(on_en[i]);
        al_x[i] += int'(al_en[i]);
      end
      if (!nn[i] && norm_m[i]) off_x[i] += int'(off_en[i]);
    end
    norm_m = nn;
  endtask : mstep
  task automatic cmp_ev();
    for (int i = 0; i < N; i++) begin
      chk("on events", on_x[i], on_n[i]);
      chk("off events", off_x[i], off_n[i]);
      chk("alarm pops", al_x[i], al_n[i]);
      bw(ADDR_SEL, i);
      br(ADDR_COUNT);
      chk("count", cnt[i], rv);
      br(ADDR_SLOT);
      chk("slot", SLOT_FIRST + i / 6, rv);
    end
  endtask : cmp_ev
  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("watchdog expired");
    results();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, wr, rd, route, light_n} = 5'h10;
    {addr, wdata, raw_n, norm_m} = '0;
    present = 12'hFEF;
    seed = 32'h2132C275;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("reset outs", 0, {state, soft_in, soft_out, peer_out});
    seed = lfsr(seed);
    {on_en, off_en} = seed[23:0];
    seed = lfsr(seed);
    {al_en, pol} = seed[23:0];
    bw(ADDR_ON_EVT, on_en);
    bw(ADDR_OFF_EVT, off_en);
    bw(ADDR_ALARM, al_en);
    bw(ADDR_POLARITY, pol);
    mstep(raw_n);
    repeat (40) begin
      seed = lfsr(seed);
      @(posedge clk);
      raw_n <= seed[N-1:0];
      mstep(seed[N-1:0]);
      repeat (6) @(posedge clk);
      #1 chk("state", norm_m, state);
      br(ADDR_STATE);
      chk("state reg", norm_m, rv);
    end
    $display("test random contacts done");
    bw(ADDR_SEL, 3);
    bw(ADDR_DELAY, 32'h1B58);
    br(ADDR_DELAY);
    chk("delay clamp", DELAY_MAX, rv);
    bw(ADDR_DELAY, 32'h2);
    rf = raw_n;
    @(posedge clk);
    raw_n <= rf ^ 12'h008;
    repeat (3) @(posedge clk);
    raw_n <= rf;
    repeat (12) @(posedge clk);
    #1 chk("glitch", norm_m, state);
    @(posedge clk);
    raw_n <= rf ^ 12'h008;
    mstep(rf ^ 12'h008);
    repeat (4) @(posedge clk);
    #1 chk("early", norm_m ^ 12'h008, state);
    repeat (16) @(posedge clk);
    #1 chk("delayed", norm_m, state);
    $display("test delay done");
    bw(ADDR_SEL, 0);
    bw(ADDR_COUNT, 32'h5);
    br(ADDR_COUNT);
    chk("locked count", cnt[0], rv);
    bw(ADDR_COUNT_LOCK, COUNT_KEY);
    bw(ADDR_COUNT, 32'hFFFF);
    cnt[0] = 65535;
    br(ADDR_COUNT);
    chk("count load", cnt[0], rv);
    repeat (2) begin
      @(posedge clk);
      raw_n <= raw_n ^ 12'h001;
      mstep(raw_n ^ 12'h001);
      repeat (6) @(posedge clk);
    end
    cmp_ev();
    $display("test counters done");
    repeat (4) begin
      seed = lfsr(seed);
      @(posedge clk);
      route <= seed[10];
      light_n <= seed[11];
      bw(ADDR_SOFT_IN, seed[3:0]);
      @(posedge clk);
      #1 chk("soft in", seed[3:0], soft_in);
      br(ADDR_SOFT_IN);
      chk("soft in reg", seed[3:0], rv);
      bw(ADDR_SOFT_OUT, seed[9:4]);
      br(ADDR_SOFT_OUT);
      chk("soft out", seed[9:4], soft_out);
      chk("soft out reg", seed[9:4], rv);
      chk("peer out", seed[10], peer_out);
      chk("peer in", seed[11], peer_in_st);
    end
    br(8'h3C);
    chk("unmapped", 0, rv);
    $display("test soft and peer done");
    results();
  end
endmodule : input_conditioning_unit_tb
`default_nettype wire

/* File: core/icu_top.sv */
// input conditioning unit: contact inputs, soft inputs, peer light pins
// What this block does
// - make polarity: a raw rise from zero to one is the active edge
// - break polarity: a raw fall from one to zero is the active edge
// - one programmable delay 0 to 60.00 s covers both on and off changes
// - active-edge event logged only while its per-input enable is set
// - inactive-edge event logged only while its per-input enable is set
// - alarm pop-up raised on active edge only while alarm option is yes
// - per-input active-edge counter 0 to 65535, writable under a key
// - one readable state bit for each fitted contact input
// - inputs grouped by card slot two to six with default numbering
// - four soft inputs and six soft outputs held only in registers
// - soft input writes from any source show as the input state
// - soft input follows its command in well under five milliseconds
// - device drives the peer light output from the routed signal
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module icu_top #(
  parameter int unsigned N_IN = 12,
  parameter int unsigned PER_SLOT = 6,
  parameter int unsigned STEP_CYC = icu_pkg::STEP_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // contact inputs
  input wire logic [N_IN-1:0] CONTACT_INPUT,
  input wire logic [N_IN-1:0] CONTACT_PRESENT,
  // conditioned states
  output logic [N_IN-1:0] CONTACT_STATE,
  output logic [icu_pkg::SOFT_IN_NUM-1:0] SOFT_INPUT,
  output logic [icu_pkg::SOFT_OUT_NUM-1:0] SOFT_OUTPUT,
  // events
  output logic [N_IN-1:0] ON_EVENT,
  output logic [N_IN-1:0] OFF_EVENT,
  output logic [N_IN-1:0] ALARM_POPUP,
  // peer relay light link
  input wire logic PEER_LIGHT_INPUT,
  input wire logic PEER_LIGHT_ROUTE,
  output logic PEER_LIGHT_IN_STATE,
  output logic PEER_LIGHT_OUTPUT
);
  import icu_pkg::*;

  localparam int IW = $clog2(N_IN);

  function automatic logic [31:0] zext(input logic [N_IN-1:0] v);
    zext = 32'h00000000;
    zext[N_IN-1:0] = v;
  endfunction : zext

  ////////////////////////////////////////////////////////////////////////
  // settings
  logic [N_IN-1:0] polarity;
  logic [N_IN-1:0] on_en;
  logic [N_IN-1:0] off_en;
  logic [N_IN-1:0] alarm_en;
  logic [IW-1:0] sel;
  logic count_unlock;
  logic [15:0] delay [N_IN];
  logic [15:0] count [N_IN];
  logic [SOFT_IN_NUM-1:0] soft_cmd;
  logic [SOFT_OUT_NUM-1:0] soft_out;
  logic sel_ok;

  assign sel_ok = 32'(sel) < N_IN;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      polarity <= '0;
      on_en <= '0;
      off_en <= '0;
      alarm_en <= '0;
      sel <= '0;
      soft_cmd <= '0;
      soft_out <= '0;
    end else if (WR) begin
      unique case (ADDR)
        ADDR_POLARITY: polarity <= WDATA[N_IN-1:0];
        ADDR_ON_EVT: on_en <= WDATA[N_IN-1:0];
        ADDR_OFF_EVT: off_en <= WDATA[N_IN-1:0];
        ADDR_ALARM: alarm_en <= WDATA[N_IN-1:0];
        ADDR_SEL: sel <= WDATA[IW-1:0];
        ADDR_SOFT_IN: soft_cmd <= WDATA[SOFT_IN_NUM-1:0];
        ADDR_SOFT_OUT: soft_out <= WDATA[SOFT_OUT_NUM-1:0];
        default: ;
      endcase
    end
  end

  // counter writes need the key first; the lock drops after one write
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      count_unlock <= 1'b0;
    end else if (WR && ADDR == ADDR_COUNT_LOCK) begin
      count_unlock <= (WDATA == COUNT_KEY);
    end else if (WR && ADDR == ADDR_COUNT) begin
      count_unlock <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // contact conditioning
  logic step_tick;
  logic [$clog2(STEP_CYC+1)-1:0] step_cnt;
  logic [N_IN-1:0] norm;
  logic [N_IN-1:0] state;
  logic [15:0] hold [N_IN];

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      step_cnt <= '0;
      step_tick <= 1'b0;
    end else if (32'(step_cnt) == STEP_CYC - 1) begin
      step_cnt <= '0;
      step_tick <= 1'b1;
    end else begin
      step_cnt <= step_cnt + 1'b1;
      step_tick <= 1'b0;
    end
  end

  // break polarity inverts, so the active edge is always a rise of norm
  assign norm = (CONTACT_INPUT ^ polarity) & CONTACT_PRESENT;

  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_in
      always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
          delay[g] <= DELAY_RESET;
        end else if (WR && ADDR == ADDR_DELAY && sel_ok && 32'(sel) == g) begin
          // clamp at sixty seconds
          delay[g] <= (WDATA[15:0] > 16'(DELAY_MAX)) ? 16'(DELAY_MAX)
                                                     : WDATA[15:0];
        end
      end

      // a bounce restarts the hold time, so no short pulse gets through
      always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
          hold[g] <= '0;
          state[g] <= 1'b0;
        end else if (norm[g] == state[g]) begin
          hold[g] <= '0;
        end else if (hold[g] >= delay[g]) begin
          state[g] <= norm[g];
          hold[g] <= '0;
        end else if (step_tick) begin
          hold[g] <= hold[g] + 16'h0001;
        end
      end

      logic rise;
      logic fall;
      assign rise = norm[g] && !state[g] && hold[g] >= delay[g];
      assign fall = !norm[g] && state[g] && hold[g] >= delay[g];

      always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
          ON_EVENT[g] <= 1'b0;
          OFF_EVENT[g] <= 1'b0;
          ALARM_POPUP[g] <= 1'b0;
        end else begin
          ON_EVENT[g] <= rise && on_en[g];
          OFF_EVENT[g] <= fall && off_en[g];
          ALARM_POPUP[g] <= rise && alarm_en[g];
        end
      end

      // a counted edge in the write cycle wins over the software value
      always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
          count[g] <= '0;
        end else if (rise) begin
          count[g] <= count[g] + 16'h0001;
        end else if (WR && ADDR == ADDR_COUNT && count_unlock && sel_ok
                     && 32'(sel) == g) begin
          count[g] <= WDATA[15:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // outputs and soft inputs
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      CONTACT_STATE <= '0;
      SOFT_INPUT <= '0;
      SOFT_OUTPUT <= '0;
    end else begin
      CONTACT_STATE <= state & CONTACT_PRESENT;
      SOFT_INPUT <= soft_cmd;
      SOFT_OUTPUT <= soft_out;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      PEER_LIGHT_IN_STATE <= 1'b0;
      PEER_LIGHT_OUTPUT <= 1'b0;
    end else begin
      PEER_LIGHT_IN_STATE <= PEER_LIGHT_INPUT;
      PEER_LIGHT_OUTPUT <= PEER_LIGHT_ROUTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port
  logic [31:0] next_rdata;
  logic [31:0] slot_of;

  always_comb begin
    slot_of = 32'h00000000;
    if (sel_ok) begin
      slot_of = SLOT_FIRST + 32'(sel) / PER_SLOT;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    unique case (ADDR)
      ADDR_STATE: next_rdata = zext(CONTACT_STATE);
      ADDR_POLARITY: next_rdata = zext(polarity);
      ADDR_ON_EVT: next_rdata = zext(on_en);
      ADDR_OFF_EVT: next_rdata = zext(off_en);
      ADDR_ALARM: next_rdata = zext(alarm_en);
      ADDR_SOFT_IN: next_rdata[SOFT_IN_NUM-1:0] = SOFT_INPUT;
      ADDR_SOFT_OUT: next_rdata[SOFT_OUT_NUM-1:0] = soft_out;
      ADDR_PRESENT: next_rdata = zext(CONTACT_PRESENT);
      ADDR_SEL: next_rdata[IW-1:0] = sel;
      ADDR_DELAY: next_rdata[15:0] = sel_ok ? delay[sel] : 16'h0000;
      ADDR_COUNT: next_rdata[15:0] = sel_ok ? count[sel] : 16'h0000;
      ADDR_COUNT_LOCK: next_rdata[0] = count_unlock;
      ADDR_SLOT: next_rdata = slot_of;
      ADDR_PEER_OUT: next_rdata[0] = PEER_LIGHT_OUTPUT;
      ADDR_PEER_IN: next_rdata[0] = PEER_LIGHT_IN_STATE;
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD ? next_rdata : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // edge checks look one cycle back, so a polarity write in the cycle
  // of a state change cannot trip them
  chk_make_edge: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    (!$past(polarity[0]) && $past(CONTACT_PRESENT[0]) && $rose(state[0]))
      |-> $past(CONTACT_INPUT[0]))
    else $error("make edge without raw high");
  chk_break_edge: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    ($past(polarity[0]) && $past(CONTACT_PRESENT[0]) && $rose(state[0]))
      |-> !$past(CONTACT_INPUT[0]))
    else $error("break edge without raw low");
  chk_zero_delay: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    (delay[0] == 16'h0000 && norm[0] != state[0])
      |=> state[0] == $past(norm[0]))
    else $error("zero delay not immediate");
  chk_delay_clamp: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    delay[0] <= 16'(DELAY_MAX))
    else $error("delay above sixty seconds");
  chk_hold_filter: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    $changed(state[0]) |-> $past(hold[0]) >= $past(delay[0]))
    else $error("state changed before hold time");
  // the on event shares the rise term with the counter, so a check on
  // both directions catches a lost pulse as well as a stray one
  chk_on_event: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    ON_EVENT[0] |-> $past(on_en[0]) && state[0])
    else $error("on event when disabled");
  chk_on_missing: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    ($rose(state[0]) && $past(on_en[0])) |-> ON_EVENT[0])
    else $error("on event missing");
  chk_off_event: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    OFF_EVENT[0] |-> $past(off_en[0]) && !state[0])
    else $error("off event when disabled");
  chk_off_missing: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    ($fell(state[0]) && $past(off_en[0])) |-> OFF_EVENT[0])
    else $error("off event missing");
  chk_alarm_popup: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    ($rose(state[0]) && $past(alarm_en[0])) |-> ALARM_POPUP[0])
    else $error("alarm pop-up missing");
  chk_alarm_quiet: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    ALARM_POPUP[0] |-> $past(alarm_en[0]) && state[0])
    else $error("alarm pop-up when disabled");
  chk_count_step: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    $rose(state[0]) |-> count[0] == $past(count[0]) + 16'h0001)
    else $error("counter did not step");
  chk_count_hold: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    (!$rose(state[0]) && !$past(WR && ADDR == ADDR_COUNT && count_unlock))
      |-> $stable(count[0]))
    else $error("counter moved without edge or write");
  chk_unlock_drop: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    $past(WR && ADDR == ADDR_COUNT) |-> !count_unlock)
    else $error("counter key not consumed");
  chk_state_mask: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    CONTACT_STATE == $past(state & CONTACT_PRESENT))
    else $error("contact state not masked");
  chk_read_idle: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    !$past(RD) |-> RDATA == 32'h00000000)
    else $error("read data outside read slot");
  chk_slot_range: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    slot_of <= SLOT_LAST)
    else $error("slot number out of range");
  chk_soft_out: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    SOFT_OUTPUT == $past(soft_out))
    else $error("soft output not reflected");
  chk_soft_follow: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    (WR && ADDR == ADDR_SOFT_IN) |=> ##1 SOFT_INPUT == $past(WDATA[3:0], 2))
    else $error("soft input not reflected");
  chk_peer_out: assert property (@(posedge CORE_CLK)
    disable iff (RESET)
    PEER_LIGHT_OUTPUT == $past(PEER_LIGHT_ROUTE))
    else $error("peer light output wrong");
  cov_rise: cover property (@(posedge CORE_CLK) disable iff (RESET) ON_EVENT[0]);
  cov_load: cover property (@(posedge CORE_CLK) disable iff (RESET)
    WR && ADDR == ADDR_COUNT && count_unlock);
  cov_fall: cover property (@(posedge CORE_CLK) disable iff (RESET) OFF_EVENT[0]);
  cov_wrap: cover property (@(posedge CORE_CLK) disable iff (RESET)
    $rose(state[0]) && count[0] == 16'h0000);
  cov_soft: cover property (@(posedge CORE_CLK) disable iff (RESET) $rose(SOFT_INPUT[0]));
endmodule : icu_top
`default_nettype wire

/* File: shared/icu_pkg.sv */
// shared constants for the input conditioning unit
package icu_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // one delay step is a hundredth of a second
  localparam int unsigned DELAY_STEP_MS = 10;
  localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * DELAY_STEP_MS;
  localparam int unsigned DELAY_MAX = 6000;
  localparam int unsigned SOFT_TIME_MS = 5;
  // a soft input settles in well under the stated bound
  localparam int unsigned SOFT_CYCLES = 2;
  localparam int unsigned SOFT_IN_NUM = 4;
  localparam int unsigned SOFT_OUT_NUM = 6;
  localparam int unsigned SLOT_FIRST = 2;
  localparam int unsigned SLOT_LAST = 6;
  localparam int unsigned SLOT_NUM = SLOT_LAST - SLOT_FIRST + 1;
  localparam int unsigned CNT_MAX = 65535;
  // register byte addresses
  localparam logic [7:0] ADDR_STATE = 8'h00;
  localparam logic [7:0] ADDR_POLARITY = 8'h04;
  localparam logic [7:0] ADDR_ON_EVT = 8'h08;
  localparam logic [7:0] ADDR_OFF_EVT = 8'h0C;
  localparam logic [7:0] ADDR_ALARM = 8'h10;
  localparam logic [7:0] ADDR_SOFT_IN = 8'h14;
  localparam logic [7:0] ADDR_SOFT_OUT = 8'h18;
  localparam logic [7:0] ADDR_PRESENT = 8'h1C;
  localparam logic [7:0] ADDR_SEL = 8'h20;
  localparam logic [7:0] ADDR_DELAY = 8'h24;
  localparam logic [7:0] ADDR_COUNT = 8'h28;
  localparam logic [7:0] ADDR_COUNT_LOCK = 8'h2C;
  localparam logic [7:0] ADDR_SLOT = 8'h30;
  localparam logic [7:0] ADDR_PEER_OUT = 8'h34;
  localparam logic [7:0] ADDR_PEER_IN = 8'h38;
  localparam logic [31:0] COUNT_KEY = 32'h0000C0DE;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
endpackage : icu_pkg
